/* hdl/sgc_device.sv */
// sgc_device: start-up sequencer, unlock guard and gain select registers
// assumes: supply_ok from the supply monitor, synchronous to clk_sys
//
// Contract
// RL1 - hold inactive 26 ms after supply threshold
// RL2 - enable in 40 ms, no access before
// RL3 - ready sets reset flag and interrupt pin
// RL4 - reset interrupt always enabled, never masked
// RL5 - host waits for reset interrupt first
// RL6 - else host waits at least 100 ms
// RL7 - host writes 0x30 to timing register
// RL8 - timing register writable only after unlock
// RL9 - key 0xAD at 0xFE unlocks timing register
// RL10 - unlock holds only for next access
// RL11 - channel A codes give gains 1..22
// RL12 - channel B codes give gains 1..16
// RL13 - voltage codes match channel B codes
// RL14 - all gain selects reset to gain 1
// RL15 - unlisted gain codes leave gain unchanged
`timescale 1ns/1ns
`default_nettype none
module sgc_device
  import sgc_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYC = SGC_HOLDOFF_CYC,
  parameter int unsigned ENABLE_CYC  = SGC_ENABLE_CYC
)(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       supply_ok,
  sgc_link_if.dev         link,
  output logic [2:0]      voltage_gain,
  output logic [2:0]      current_a_gain,
  output logic [2:0]      current_b_gain,
  output logic [7:0]      timing_cfg,
  output logic            dev_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (HOLDOFF_CYC < 1 || HOLDOFF_CYC >= (1 << SGC_CNT_W) ||
      ENABLE_CYC < 1 || ENABLE_CYC >= (1 << SGC_CNT_W))
  begin : g_chk
    $error("sgc_device: start-up counts out of counter range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [1:0] {DV_INACTIVE, DV_HOLDOFF, DV_ENABLING, DV_READY} sgc_dphase_type;

  typedef struct packed {
    sgc_dphase_type       phase;
    logic [SGC_CNT_W-1:0] cnt;
    logic [2:0]           vgain;
    logic [2:0]           again;
    logic [2:0]           bgain;
    logic [7:0]           tcfg;
    logic                 key_armed;
    logic                 rst_flag;
    logic                 ack;
    logic [31:0]          rdata;
  } sgc_dstate_type;

  localparam sgc_dstate_type DEV_RST = '{
    phase:     DV_INACTIVE,
    cnt:       '0,
    vgain:     SGC_GAIN_1,
    again:     SGC_GAIN_1,
    bgain:     SGC_GAIN_1,
    tcfg:      SGC_TIMING_RST,
    key_armed: 1'b0,
    rst_flag:  1'b0,
    ack:       1'b0,
    rdata:     '0
  };

  sgc_dstate_type s_r;
  sgc_dstate_type s_nxt;

  // code is legal when listed for the channel; gain 22 only where allowed
  function automatic logic sgc_gain_ok(input logic [2:0] code, input logic allow22);
    sgc_gain_ok = (code <= SGC_GAIN_16) || (allow22 && code == SGC_GAIN_22);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    unique case (s_r.phase)
      DV_INACTIVE:
      begin
        s_nxt.cnt = '0;
        if (supply_ok)
        begin
          s_nxt.phase = DV_HOLDOFF;
        end
      end
      DV_HOLDOFF:
      begin
        // supply allowed to settle before any circuitry wakes
        if (s_r.cnt == SGC_CNT_W'(HOLDOFF_CYC - 1))                 // [RL1]
        begin
          s_nxt.cnt   = '0;
          s_nxt.phase = DV_ENABLING;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt + SGC_CNT_W'(1);
        end
      end
      DV_ENABLING:
      begin
        if (s_r.cnt == SGC_CNT_W'(ENABLE_CYC - 1))                  // [RL2]
        begin
          s_nxt.cnt      = '0;
          s_nxt.phase    = DV_READY;
          s_nxt.rst_flag = 1'b1;                                     // [RL3] [RL4]
        end
        else
        begin
          s_nxt.cnt = s_r.cnt + SGC_CNT_W'(1);
        end
      end
      DV_READY:
      begin
        // one access per request; s_r.ack blocks a double take of a held req
        if (link.req && !s_r.ack)
        begin
          s_nxt.ack       = 1'b1;
          s_nxt.rdata     = '0;
          s_nxt.key_armed = 1'b0;                                    // [RL10]
          if (link.we)
          begin
            unique case (link.addr)
              SGC_A_UNLOCK_KEY:
                s_nxt.key_armed = (link.wdata == SGC_UNLOCK_VALUE);  // [RL9]
              SGC_A_TIMING_CFG:
                if (s_r.key_armed)                                   // [RL8] [RL10]
                begin
                  s_nxt.tcfg = link.wdata;
                end
              SGC_A_CURRENT_A_GAIN:
                if (sgc_gain_ok(link.wdata[2:0], 1'b1) && link.wdata[7:3] == '0) // [RL11] [RL15]
                begin
                  s_nxt.again = link.wdata[2:0];
                end
              SGC_A_CURRENT_B_GAIN:
                if (sgc_gain_ok(link.wdata[2:0], 1'b0) && link.wdata[7:3] == '0) // [RL12] [RL15]
                begin
                  s_nxt.bgain = link.wdata[2:0];
                end
              SGC_A_VOLTAGE_GAIN:
                if (sgc_gain_ok(link.wdata[2:0], 1'b0) && link.wdata[7:3] == '0) // [RL13] [RL15]
                begin
                  s_nxt.vgain = link.wdata[2:0];
                end
              default:
                s_nxt.key_armed = 1'b0;
            endcase
          end
          else
          begin
            unique case (link.addr)
              SGC_A_VOLTAGE_GAIN:   s_nxt.rdata[2:0] = s_r.vgain;
              SGC_A_CURRENT_A_GAIN: s_nxt.rdata[2:0] = s_r.again;
              SGC_A_CURRENT_B_GAIN: s_nxt.rdata[2:0] = s_r.bgain;
              SGC_A_TIMING_CFG:     s_nxt.rdata[7:0] = s_r.tcfg;
              SGC_A_IRQ_STAT:       s_nxt.rdata[SGC_RESET_BIT] = s_r.rst_flag;
              SGC_A_IRQ_STAT_CLR:
              begin
                // flag only sets on entry to ready, so no set can collide here
                s_nxt.rdata[SGC_RESET_BIT] = s_r.rst_flag;
                s_nxt.rst_flag = 1'b0;
              end
              default:              s_nxt.rdata = '0;
            endcase
          end
        end
      end
    endcase
    // supply loss drops everything back to the inactive state
    if (!supply_ok)
    begin
      s_nxt = DEV_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_r <= DEV_RST;                                                // [RL14]
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign link.ack       = s_r.ack;
  assign link.rdata     = s_r.rdata;
  assign link.irq_n     = ~s_r.rst_flag;  // no mask on this source  [RL3] [RL4]
  assign voltage_gain   = s_r.vgain;
  assign current_a_gain = s_r.again;
  assign current_b_gain = s_r.bgain;
  assign timing_cfg     = s_r.tcfg;
  assign dev_ready      = (s_r.phase == DV_READY);

endmodule
`default_nettype wire

/* hdl/sgc_host.sv */
// sgc_host: controller end; brings the device up, then runs software commands
// assumes: software on AXI4-Lite; device end joined through sgc_link_if
`timescale 1ns/1ns
`default_nettype none
module sgc_host
  import sgc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = SGC_TIMEOUT_CYC
)(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             irq,
  sgc_link_if.host         link
);

  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC >= (1 << SGC_CNT_W))
  begin : g_chk
    $error("sgc_host: timeout out of counter range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [2:0] {HS_WAIT, HS_CLEAR, HS_KEY, HS_CFG, HS_IDLE, HS_CMD} sgc_hphase_type;

  typedef struct packed {
    sgc_hphase_type       phase;
    logic [SGC_CNT_W-1:0] cnt;
    logic                 req;
    logic                 we;
    logic [9:0]           addr;
    logic [7:0]           wdata;
    logic                 cmd_pend;
    logic                 cmd_we;
    logic [9:0]           cmd_addr;
    logic [7:0]           cmd_wdata;
    logic [31:0]          result;
    logic                 dev_up;
    logic [1:0]           istat;
    logic [1:0]           imask;
    logic                 aw_got;
    logic [7:0]           awaddr;
    logic                 w_got;
    logic [31:0]          wd;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
  } sgc_hstate_type;

  sgc_hstate_type s_r;
  sgc_hstate_type s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic [1:0]  ev;
    logic [1:0]  clr;
    logic        aw_fire;
    logic        w_fire;
    logic [7:0]  wa;
    logic [31:0] wv;
    ev      = '0;
    clr     = '0;
    aw_fire = s_axi_awvalid && s_axi_awready;
    w_fire  = s_axi_wvalid && s_axi_wready;
    wa      = s_r.aw_got ? s_r.awaddr : s_axi_awaddr;
    wv      = s_r.w_got ? s_r.wd : s_axi_wdata;
    s_nxt   = s_r;
    // link side: request held until the device acks
    if (link.ack)
    begin
      s_nxt.req = 1'b0;
    end
    unique case (s_r.phase)
      HS_WAIT:
      begin
        s_nxt.cnt = s_r.cnt + SGC_CNT_W'(1);
        if (!link.irq_n)                                             // [RL5]
        begin
          s_nxt.phase = HS_CLEAR;
          s_nxt.req   = 1'b1;
          s_nxt.we    = 1'b0;
          s_nxt.addr  = SGC_A_IRQ_STAT_CLR;
        end
        else if (s_r.cnt == SGC_CNT_W'(TIMEOUT_CYC - 1))             // [RL6]
        begin
          s_nxt.phase = HS_KEY;
          s_nxt.req   = 1'b1;
          s_nxt.we    = 1'b1;
          s_nxt.addr  = SGC_A_UNLOCK_KEY;
          s_nxt.wdata = SGC_UNLOCK_VALUE;
        end
      end
      HS_CLEAR:
        if (link.ack)
        begin
          ev[SGC_EV_RESET] = 1'b1;
          s_nxt.phase = HS_KEY;
          s_nxt.req   = 1'b1;
          s_nxt.we    = 1'b1;
          s_nxt.addr  = SGC_A_UNLOCK_KEY;
          s_nxt.wdata = SGC_UNLOCK_VALUE;                             // [RL9]
        end
      HS_KEY:
        if (link.ack)
        begin
          // very next access is the protected write, nothing in between
          s_nxt.phase = HS_CFG;
          s_nxt.req   = 1'b1;
          s_nxt.we    = 1'b1;
          s_nxt.addr  = SGC_A_TIMING_CFG;
          s_nxt.wdata = SGC_TIMING_OPTIMUM;                           // [RL7] [RL10]
        end
      HS_CFG:
        if (link.ack)
        begin
          s_nxt.phase  = HS_IDLE;
          s_nxt.dev_up = 1'b1;
        end
      HS_IDLE:
        if (!link.irq_n)
        begin
          // device went through another reset: redo the bring-up
          s_nxt.dev_up = 1'b0;
          s_nxt.phase  = HS_CLEAR;
          s_nxt.req    = 1'b1;
          s_nxt.we     = 1'b0;
          s_nxt.addr   = SGC_A_IRQ_STAT_CLR;
        end
        else if (s_r.cmd_pend)
        begin
          s_nxt.cmd_pend = 1'b0;
          s_nxt.phase    = HS_CMD;
          s_nxt.req      = 1'b1;
          s_nxt.we       = s_r.cmd_we;
          s_nxt.addr     = s_r.cmd_addr;
          s_nxt.wdata    = s_r.cmd_wdata;
        end
      HS_CMD:
        if (link.ack)
        begin
          ev[SGC_EV_DONE] = 1'b1;
          s_nxt.result = link.rdata;
          s_nxt.phase  = HS_IDLE;
        end
      default:
        s_nxt.phase = HS_WAIT;
    endcase

    // axi write: address and data taken in either order
    if (aw_fire)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (w_fire)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wd    = s_axi_wdata;
    end
    if ((s_r.aw_got || aw_fire) && (s_r.w_got || w_fire))
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = SGC_RESP_OKAY;
      unique case (wa)
        SGC_R_CMD:
          // a command while one is pending is dropped; software polls busy
          if (!s_r.cmd_pend && s_axi_wstrb == 4'hF)
          begin
            s_nxt.cmd_pend  = 1'b1;
            s_nxt.cmd_we    = wv[SGC_CMD_WE_BIT];
            s_nxt.cmd_addr  = wv[SGC_CMD_A_LSB +: SGC_ADDR_W];
            s_nxt.cmd_wdata = wv[SGC_DATA_W-1:0];
          end
        SGC_R_ISTAT:
          clr = wv[1:0];
        SGC_R_IMASK:
          s_nxt.imask = wv[1:0];
        default:
          s_nxt.bresp = SGC_RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
    end

    // axi read
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = SGC_RESP_OKAY;
      s_nxt.rdata  = '0;
      unique case (s_axi_araddr)
        SGC_R_CMD:    s_nxt.rdata = {s_r.cmd_we, 5'h00, s_r.cmd_addr, 8'h00, s_r.cmd_wdata};
        SGC_R_RDATA:  s_nxt.rdata = s_r.result;
        SGC_R_STATUS: s_nxt.rdata[1:0] = {s_r.dev_up, s_r.cmd_pend || s_r.phase == HS_CMD};
        SGC_R_ISTAT:  s_nxt.rdata[1:0] = s_r.istat;
        SGC_R_IMASK:  s_nxt.rdata[1:0] = s_r.imask;
        default:      s_nxt.rresp = SGC_RESP_SLVERR;
      endcase
    end
    else if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
    end

    // sticky events: a set in the clearing cycle wins
    s_nxt.istat = (s_r.istat & ~clr) | ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_r       <= '0;
      s_r.phase <= HS_WAIT;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign irq           = |(s_r.istat & s_r.imask);
  assign link.req      = s_r.req;
  assign link.we       = s_r.we;
  assign link.addr     = s_r.addr;
  assign link.wdata    = s_r.wdata;

endmodule
`default_nettype wire

/* hdl/sgc_link_if.sv */
// sgc_link_if: register access link between controller and device
// assumes: both ends on clk_sys; req held until a one-cycle ack
`timescale 1ns/1ns
`default_nettype none
interface sgc_link_if;
  logic        req;
  logic        we;
  logic [9:0]  addr;
  logic [7:0]  wdata;
  logic        ack;
  logic [31:0] rdata;
  logic        irq_n;

  modport dev  (input req, input we, input addr, input wdata,
                output ack, output rdata, output irq_n);
  modport host (output req, output we, output addr, output wdata,
                input ack, input rdata, input irq_n);
endinterface
`default_nettype wire

/* hdl/sgc_pkg.sv */
// sgc_pkg: shared constants of the start-up and gain configuration link
// assumes: a single 10 MHz system clock on both ends of the link
package sgc_pkg;

  // clock and start-up timing
  localparam int unsigned SGC_CLK_HZ      = 10_000_000;
  localparam int unsigned SGC_HOLDOFF_MS  = 26;
  localparam int unsigned SGC_ENABLE_MS   = 40;
  localparam int unsigned SGC_TIMEOUT_MS  = 100;
  localparam int unsigned SGC_HOLDOFF_CYC = SGC_HOLDOFF_MS * (SGC_CLK_HZ / 1000);
  localparam int unsigned SGC_ENABLE_CYC  = SGC_ENABLE_MS * (SGC_CLK_HZ / 1000);
  localparam int unsigned SGC_TIMEOUT_CYC = SGC_TIMEOUT_MS * (SGC_CLK_HZ / 1000);
  localparam int unsigned SGC_CNT_W       = 20;

  // link widths
  localparam int unsigned SGC_ADDR_W = 10;
  localparam int unsigned SGC_DATA_W = 8;
  localparam int unsigned SGC_RD_W   = 32;

  // device register map
  localparam logic [9:0] SGC_A_VOLTAGE_GAIN  = 10'h007;
  localparam logic [9:0] SGC_A_CURRENT_A_GAIN = 10'h008;
  localparam logic [9:0] SGC_A_CURRENT_B_GAIN = 10'h009;
  localparam logic [9:0] SGC_A_UNLOCK_KEY    = 10'h0FE;
  localparam logic [9:0] SGC_A_TIMING_CFG    = 10'h120;
  localparam logic [9:0] SGC_A_IRQ_STAT      = 10'h22D;
  localparam logic [9:0] SGC_A_IRQ_STAT_CLR  = 10'h32D;

  // key, timing setting, reset-complete flag position, gain codes
  localparam logic [7:0] SGC_UNLOCK_VALUE   = 8'hAD;
  localparam logic [7:0] SGC_TIMING_OPTIMUM = 8'h30;
  localparam logic [7:0] SGC_TIMING_RST     = 8'h00;
  localparam int unsigned SGC_RESET_BIT     = 20;
  localparam logic [2:0] SGC_GAIN_1         = 3'h0;
  localparam logic [2:0] SGC_GAIN_16        = 3'h4;
  localparam logic [2:0] SGC_GAIN_22        = 3'h5;

  // controller register map over AXI4-Lite
  localparam logic [7:0] SGC_R_CMD    = 8'h00;
  localparam logic [7:0] SGC_R_RDATA  = 8'h04;
  localparam logic [7:0] SGC_R_STATUS = 8'h08;
  localparam logic [7:0] SGC_R_ISTAT  = 8'h0C;
  localparam logic [7:0] SGC_R_IMASK  = 8'h10;
  localparam int unsigned SGC_CMD_WE_BIT = 31;
  localparam int unsigned SGC_CMD_A_LSB  = 16;
  localparam int unsigned SGC_EV_DONE    = 0;
  localparam int unsigned SGC_EV_RESET   = 1;
  localparam logic [1:0] SGC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SGC_RESP_SLVERR = 2'h2;

endpackage

/* verif/sgc_link_checker.sv */
// sgc_link_checker: timing and order checks on the host-device link
// assumes: sits beside sgc_link_if, everything on clk_sys
`timescale 1ns/1ns
`default_nettype none
module sgc_link_checker
  import sgc_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYC = SGC_HOLDOFF_CYC,
  parameter int unsigned ENABLE_CYC  = SGC_ENABLE_CYC
)(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        supply_ok,
  input wire logic        req,
  input wire logic        we,
  input wire logic [9:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        ack,
  input wire logic [31:0] rdata,
  input wire logic        irq_n
);
  localparam int unsigned UP_MIN = HOLDOFF_CYC + ENABLE_CYC - 2;
  localparam int unsigned UP_MAX = HOLDOFF_CYC + ENABLE_CYC + 8;
  logic [19:0] up_cnt_r;
  logic        seen_r;
  logic        boot_r;
  // supply loss resets the device, so it also restarts the bookkeeping
  wire logic   off = srst || !supply_ok;
  wire logic   rd_clr = req && !we && addr == SGC_A_IRQ_STAT_CLR;

  ////////////////////////////////////////////////////////////
  // cycles since power-up, saturating so it never wraps
  always_ff @(posedge clk_sys)
  begin
    if (off)
    begin
      up_cnt_r <= '0;
      seen_r   <= 1'b0;
      boot_r   <= 1'b0;
    end
    else
    begin
      if (up_cnt_r != 20'hFFFFF)
        up_cnt_r <= up_cnt_r + 20'h1;
      seen_r <= seen_r | !irq_n;
      boot_r <= boot_r | (ack && we && addr == SGC_A_TIMING_CFG);
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (off);
  hold_off_a:
    assert property (up_cnt_r < UP_MIN |-> irq_n && !ack)
    else $error("device woke before its hold-off");
  ready_late_a:
    assert property (up_cnt_r == UP_MAX |-> seen_r)
    else $error("start-up too late");
  ack_time_a:
    assert property (req && !ack && seen_r |=> ack)
    else $error("no answer the next cycle");
  ack_pulse_a:
    assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  rst_flag_a:
    assert property (rd_clr && !ack && !irq_n |=> ack && rdata[SGC_RESET_BIT])
    else $error("reset flag not reported");
  irq_hold_a:
    assert property (!irq_n && !rd_clr |=> !irq_n)
    else $error("interrupt dropped without clear");
  irq_clear_a:
    assert property ($rose(irq_n) |-> $past(rd_clr))
    else $error("interrupt rose without cause");
  unlock_seq_a:
    assert property (ack && we && addr == SGC_A_UNLOCK_KEY && !boot_r |-> ##[1:4]
      (req && we && addr == SGC_A_TIMING_CFG && wdata == SGC_TIMING_OPTIMUM))
    else $error("key not followed by timing write");
  first_req_a:
    assert property (req |-> seen_r)
    else $error("access before reset interrupt");
  cover property (rd_clr && ack);
  cover property (ack && we && addr == SGC_A_TIMING_CFG);
  cover property ($fell(irq_n));
endmodule
`default_nettype wire

/* verif/startup_and_gain_config_test.sv */
// startup_and_gain_config_test: host and device ends joined, software over AXI4-Lite
// assumes: bench plays the supply monitor; short start-up counts
`timescale 1ns/1ns
`default_nettype none
module startup_and_gain_config_test
  import sgc_pkg::*;
;
  localparam int unsigned HOLD_C = 20;
  localparam int unsigned EN_C   = 30;
  localparam int unsigned LIM    = 400;
  logic        clk_sys, srst, supply_ok, irq, dev_ready;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, tcfg;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  gain [3];
  logic [2:0]  eg [3];
  int          fails, check_count;

  ////////////////////////////////////////////////////////////
  sgc_link_if link ();
  sgc_device #(.HOLDOFF_CYC(HOLD_C), .ENABLE_CYC(EN_C)) i_sgc_device (
    .clk_sys(clk_sys), .srst(srst), .supply_ok(supply_ok), .link(link),
    .voltage_gain(gain[0]), .current_a_gain(gain[1]), .current_b_gain(gain[2]),
    .timing_cfg(tcfg), .dev_ready(dev_ready));
  sgc_host #(.TIMEOUT_CYC(LIM)) i_sgc_host (
    .clk_sys(clk_sys), .srst(srst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .irq(irq),
    .link(link));
  sgc_link_checker #(.HOLDOFF_CYC(HOLD_C), .ENABLE_CYC(EN_C)) i_sgc_link_checker (
    .clk_sys(clk_sys), .srst(srst), .supply_ok(supply_ok), .req(link.req),
    .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
    .rdata(link.rdata), .irq_n(link.irq_n));

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // a spent wait bound means a hang: stop here
  task automatic guard(input int n);
    if (n >= LIM)
    begin
      fails++;
      $display("MISMATCH wait exp done got timeout");
      final_report();
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw = 1'b1;
    logic w = 1'b1;
    int   n = 0;
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (n < LIM && !(bvalid && !aw && !w))
    begin
      @(posedge clk_sys);
      aw = aw && !awready;
      w = w && !wready;
      awvalid <= aw;
      wvalid <= w;
      n++;
    end
    bready <= 1'b0;
    guard(n);
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ar = 1'b1;
    int   n = 0;
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (n < LIM && !(rvalid && !ar))
    begin
      @(posedge clk_sys);
      ar = ar && !arready;
      arvalid <= ar;
      n++;
    end
    rready <= 1'b0;
    d = rdata;
    guard(n);
    chk("rresp", 32'(er), 32'(rresp));
  endtask

  // launch one link access and poll until the controller is idle
  task automatic cmd(input logic w, input logic [9:0] a, input logic [7:0] d);
    logic [31:0] s = 32'h1;
    int          n = 0;
    wr(SGC_R_CMD, {w, 5'h0, a, 8'h0, d}, SGC_RESP_OKAY);
    while (s[0] && n < LIM)
    begin
      rd(SGC_R_STATUS, s, SGC_RESP_OKAY);
      n++;
    end
    guard(n);
  endtask

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'(e), 32'(irq));
  endtask

  task automatic wait_boot();
    int n = 0;
    while (tcfg !== SGC_TIMING_OPTIMUM && n < LIM)
    begin
      @(posedge clk_sys);
      n++;
    end
    guard(n);
    repeat (4) @(posedge clk_sys);
  endtask

  // reserved codes leave the applied gain as it was
  function automatic logic [2:0] gain_exp(input int ch, input logic [7:0] c,
                                          input logic [2:0] g);
    if (c < 8'h05 || (c == 8'h05 && ch == 1))
      return c[2:0];
    return g;
  endfunction

  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] v;
    logic [7:0]  d;
    int          n;
    clk_sys = 1'b0;
    srst = 1'b1;
    supply_ok = 1'b0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {fails, check_count} = '0;
    eg = '{SGC_GAIN_1, SGC_GAIN_1, SGC_GAIN_1};
    v = $urandom(35248);
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    // supply still low: device stays inactive with reset values
    chk("ready_off", 0, 32'(dev_ready));
    for (int i = 0; i < 3; i++)
      chk("gain_rst", 32'(SGC_GAIN_1), 32'(gain[i]));
    supply_ok <= 1'b1;
    n = 0;
    while (!dev_ready && n < LIM)
    begin
      @(posedge clk_sys);
      n++;
    end
    guard(n);
    chk("ready_time", 1, 32'(n >= HOLD_C + EN_C - 2 && n <= HOLD_C + EN_C + 8));
    wait_boot();
    rd(SGC_R_STATUS, v, SGC_RESP_OKAY);
    chk("dev_up", 1, 32'(v[1]));
    rd(SGC_R_ISTAT, v, SGC_RESP_OKAY);
    chk("rst_seen", 1, 32'(v[SGC_EV_RESET]));
    rd(SGC_R_IMASK, v, SGC_RESP_OKAY);
    chk("mask_rst", 0, v);
    chk_irq(1'b0);
    wr(SGC_R_IMASK, 32'h2, SGC_RESP_OKAY);
    chk_irq(1'b1);
    wr(SGC_R_ISTAT, 32'h2, SGC_RESP_OKAY);
    chk_irq(1'b0);
    // unmapped and read-only places are refused
    wr(8'h14, 32'h0, SGC_RESP_SLVERR);
    rd(8'h14, v, SGC_RESP_SLVERR);
    wr(SGC_R_STATUS, 32'h0, SGC_RESP_SLVERR);
    // every code on every channel, then random bytes
    for (int ch = 0; ch < 3; ch++)
      for (int i = 0; i < 12; i++)
      begin
        d = (i < 8) ? 8'(i) : 8'($urandom);
        cmd(1'b1, 10'(7 + ch), d);
        eg[ch] = gain_exp(ch, d, eg[ch]);
        chk("gain", 32'(eg[ch]), 32'(gain[ch]));
        cmd(1'b0, 10'(7 + ch), 8'h0);
        rd(SGC_R_RDATA, v, SGC_RESP_OKAY);
        chk("gain_rd", 32'(eg[ch]), v);
      end
    cmd(1'b1, SGC_A_TIMING_CFG, 8'h55);
    chk("locked", 32'(SGC_TIMING_OPTIMUM), 32'(tcfg));
    cmd(1'b1, SGC_A_UNLOCK_KEY, SGC_UNLOCK_VALUE);
    cmd(1'b0, SGC_A_VOLTAGE_GAIN, 8'h0);
    cmd(1'b1, SGC_A_TIMING_CFG, 8'h55);
    chk("disarmed", 32'(SGC_TIMING_OPTIMUM), 32'(tcfg));
    cmd(1'b1, SGC_A_UNLOCK_KEY, SGC_UNLOCK_VALUE ^ 8'h01);
    cmd(1'b1, SGC_A_TIMING_CFG, 8'h55);
    chk("bad_key", 32'(SGC_TIMING_OPTIMUM), 32'(tcfg));
    d = 8'($urandom);
    cmd(1'b1, SGC_A_UNLOCK_KEY, SGC_UNLOCK_VALUE);
    cmd(1'b1, SGC_A_TIMING_CFG, d);
    chk("unlocked", 32'(d), 32'(tcfg));
    cmd(1'b1, SGC_A_TIMING_CFG, ~d);
    chk("one_shot", 32'(d), 32'(tcfg));
    cmd(1'b0, SGC_A_IRQ_STAT, 8'h0);
    rd(SGC_R_RDATA, v, SGC_RESP_OKAY);
    chk("flag_clr", 0, 32'(v[SGC_RESET_BIT]));
    // supply loss: full reset, then a fresh start-up and interrupt
    supply_ok <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("drop", 32'({SGC_GAIN_1, SGC_GAIN_1, SGC_GAIN_1, SGC_TIMING_RST}),
        32'({gain[0], gain[1], gain[2], tcfg}));
    supply_ok <= 1'b1;
    wait_boot();
    rd(SGC_R_ISTAT, v, SGC_RESP_OKAY);
    chk("rst_again", 1, 32'(v[SGC_EV_RESET]));
    chk_irq(1'b1);
    final_report();
  end
endmodule
`default_nettype wire
